// *** common/pwm_regs.svh ***
// Function
// (RQ1) Two-bit select picks one of three timers
// (RQ2) Period is (limit+1) x 4 x prescale clocks
// (RQ3) Timer clears on increment after limit match
// (RQ4) Pin set at period start unless duty zero
// (RQ5) Duty copied into active buffer at start
// (RQ6) Duty: eight high bits, two in control
// (RQ7) Software writes anytime; applied next period
// (RQ8) Active duty register read-only while running
// (RQ9) Active byte plus hidden latch double buffer
// (RQ10) Time base: count plus phase or prescaler
// (RQ11) Time base equals duty clears the pin
// (RQ12) High time is duty x clock x prescale
// (RQ13) Postscaler never affects period
// (RQ14) Duty beyond period leaves pin unchanged
// (RQ15) Resolution reaches ten bits at limit 255
// (RQ16) Prescale ratios are 1, 4 and 16
// (RQ17) Sleep freezes timer, state and pin
// (RQ18) Output rate follows the system clock
// (RQ19) Reset makes pin input, registers default
// (RQ20) Pin location selectable, default after reset
// (RQ21) Direction bit clear enables the driver
// (RQ22) Runs only in PWM mode, timer enabled
`ifndef PWM_REGS_SVH
`define PWM_REGS_SVH
// Register indices on the plain register port
`define ADDR_PIN_RELOC     4'h0
`define ADDR_MODULE_CTRL   4'h1
`define ADDR_TIMER_SELECT  4'h2
`define ADDR_PERIOD_LIMIT  4'h3
`define ADDR_TIMER_CTRL    4'h4
`define ADDR_TIMER_COUNT   4'h5
`define ADDR_DUTY_LOW      4'h6
`define ADDR_DUTY_ACTIVE   4'h7
`define ADDR_PIN_DIR       4'h8
// Field positions
`define DUTY_LSB_HI        5
`define DUTY_LSB_LO        4
`define MODE_HI            3
`define TIMER_EN_BIT       2
`define PWM_MODE_HI        2'h3
`define PIN_RELOC_BIT      0
// Reset values
`define RESET_BYTE         8'h00
`define RESET_PERIOD       8'hff
`define RESET_PIN_DIR      8'hff
`endif

// *** common/pwm_pkg.sv ***
package pwm_pkg;
  // Timer prescale choice, two-bit field code
  typedef enum logic [1:0] {PRE_1, PRE_4, PRE_16, PRE_16B} prescale_e;
  // Register index type
  typedef logic [3:0] addr_t;
endpackage : pwm_pkg

// *** logic/standard_pwm.sv ***
`timescale 1ns/1ps
`include "pwm_regs.svh"
module standard_pwm #(
  parameter int unsigned MODULE_SEL = 0        // Which select field of the shared register
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              sleep,         // Device sleep, freezes timers, phase and modulated level; register port still works
  input  wire pwm_pkg::addr_t    addr,
  input  wire logic [7:0]        wrData,
  input  wire logic              wrStb,
  input  wire logic              rdStb,
  output logic      [7:0]        rdData,
  output logic                   pinOutA,       // Default pin location
  output logic                   pinOeA,
  output logic                   pinOutB,       // Alternate pin location
  output logic                   pinOeB
);
  // Software registers
  logic [7:0] pinReloc;      // Pin location select
  logic [7:0] moduleCtrl;    // Mode field and duty low bits
  logic [7:0] timerSelect;   // Shared timer select, two bits per module
  logic [7:0] periodLimit [3];
  logic [7:0] timerCtrl   [3];
  logic [7:0] timerCount  [3];
  logic [3:0] prescaleCnt [3];
  logic [7:0] dutyLow;       // Software duty byte
  logic [7:0] dutyActive;    // Active duty byte
  logic [1:0] dutyLatch;     // Hidden low bits of active duty
  logic [7:0] pinDir;        // Direction bits, one means input
  logic [1:0] phase;         // Internal clock phase at 1:1
  logic       pwmLevel;      // Modulated level
  logic       compareDone;   // Clear already happened this period

  // Decoded controls
  logic       pwmMode;
  logic [1:0] sel;
  logic [1:0] timerIdx;
  logic [9:0] timeBase;
  logic       baseStep;      // Time base moves one step at this edge
  logic [9:0] baseNext;      // Time base value after this edge
  logic       active;
  logic [2:0] tick;          // Per-timer increment enables
  logic [2:0] match;         // Per-timer limit matches
  logic [2:0] wrap;          // Per-timer period start

  assign pwmMode = moduleCtrl[`MODE_HI:`MODE_HI-1] == `PWM_MODE_HI;                // see (RQ22)
  assign sel     = timerSelect[2*MODULE_SEL+1 -: 2];                               // see (RQ1)
  assign timerIdx = (sel == 2'h3) ? 2'h0 : sel;                                    // see (RQ1)
  assign active  = pwmMode && !sleep;                                              // see (RQ17)

  // Prescale tick per timer; postscale bits 6:3 never used  see (RQ13) (RQ16)
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      unique case (pwm_pkg::prescale_e'(timerCtrl[i][1:0]))
        pwm_pkg::PRE_1:  tick[i] = phase == 2'h3;
        pwm_pkg::PRE_4:  tick[i] = phase == 2'h3 && prescaleCnt[i][1:0] == 2'h3;
        default:         tick[i] = phase == 2'h3 && prescaleCnt[i] == 4'hf;
      endcase
      tick[i]  = tick[i] && timerCtrl[i][`TIMER_EN_BIT] && !sleep;                // see (RQ22) (RQ17)
      match[i] = timerCount[i] == periodLimit[i];
      wrap[i]  = tick[i] && match[i];                                              // see (RQ3)
    end
  end

  // Ten-bit time base: count plus phase or prescaler bits  see (RQ10)
  // The step flag lets the compare act on the edge that reaches the duty
  always_comb begin
    unique case (pwm_pkg::prescale_e'(timerCtrl[timerIdx][1:0]))
      pwm_pkg::PRE_1: begin
        timeBase = {timerCount[timerIdx], phase};
        baseStep = 1'b1;
      end
      pwm_pkg::PRE_4: begin
        timeBase = {timerCount[timerIdx], prescaleCnt[timerIdx][1:0]};
        baseStep = phase == 2'h3;
      end
      default: begin
        timeBase = {timerCount[timerIdx], prescaleCnt[timerIdx][3:2]};
        baseStep = phase == 2'h3 && prescaleCnt[timerIdx][1:0] == 2'h3;
      end
    endcase
    baseStep = baseStep && timerCtrl[timerIdx][`TIMER_EN_BIT] && !sleep;          // see (RQ17)
  end

  // Ten bits on purpose; the wrap branch has priority at the end of a period
  assign baseNext = timeBase + 10'h001;

  // Four-phase clock divider; one prescaler step per four clocks  see (RQ2) (RQ18)
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase <= 2'h0;
    end else if (!sleep) begin
      phase <= phase + 2'h1;
    end
  end

  // Timers and prescalers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < 3; i++) begin
        timerCount[i]  <= `RESET_BYTE;                                             // see (RQ19)
        prescaleCnt[i] <= 4'h0;
      end
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wrStb && addr == `ADDR_TIMER_COUNT && i == timerIdx) begin
          timerCount[i] <= wrData;
        end else if (wrap[i]) begin
          timerCount[i] <= `RESET_BYTE;                                            // see (RQ3)
        end else if (tick[i]) begin
          timerCount[i] <= timerCount[i] + 8'h01;
        end
        if (phase == 2'h3 && timerCtrl[i][`TIMER_EN_BIT] && !sleep) begin
          prescaleCnt[i] <= prescaleCnt[i] + 4'h1;
        end
      end
    end
  end

  // Software-writable registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pinReloc    <= `RESET_BYTE;                                                  // see (RQ20)
      moduleCtrl  <= `RESET_BYTE;
      timerSelect <= `RESET_BYTE;
      dutyLow     <= `RESET_BYTE;
      pinDir      <= `RESET_PIN_DIR;                                               // see (RQ19)
      for (int i = 0; i < 3; i++) begin
        periodLimit[i] <= `RESET_PERIOD;
        timerCtrl[i]   <= `RESET_BYTE;
      end
    end else if (wrStb) begin
      unique case (addr)
        `ADDR_PIN_RELOC:    pinReloc    <= wrData;                                  // see (RQ20)
        `ADDR_MODULE_CTRL:  moduleCtrl  <= wrData;                                  // see (RQ6) (RQ7)
        `ADDR_TIMER_SELECT: timerSelect <= wrData;
        `ADDR_PERIOD_LIMIT: periodLimit[timerIdx] <= wrData;                        // see (RQ15)
        `ADDR_TIMER_CTRL:   timerCtrl[timerIdx]   <= {1'b0, wrData[6:0]};
        `ADDR_DUTY_LOW:     dutyLow     <= wrData;                                  // see (RQ7)
        `ADDR_PIN_DIR:      pinDir      <= wrData;                                  // see (RQ21)
        default: ;
      endcase
    end
  end

  // Double-buffered duty; active byte ignores writes while in PWM  see (RQ8) (RQ9)
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dutyActive <= `RESET_BYTE;
      dutyLatch  <= 2'h0;
    end else if (active && wrap[timerIdx]) begin
      dutyActive <= dutyLow;                                                       // see (RQ5)
      dutyLatch  <= moduleCtrl[`DUTY_LSB_HI:`DUTY_LSB_LO];                          // see (RQ6)
    end else if (!pwmMode && wrStb && addr == `ADDR_DUTY_ACTIVE) begin
      dutyActive <= wrData;                                                        // see (RQ8)
    end
  end

  // Output level: set at period start, cleared on compare match
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwmLevel    <= 1'b0;
      compareDone <= 1'b0;
    end else if (!pwmMode) begin
      pwmLevel    <= 1'b0;                                                         // see (RQ22)
      compareDone <= 1'b0;
    end else if (active && wrap[timerIdx]) begin
      // Zero duty keeps the pin low  see (RQ4)
      pwmLevel    <= {dutyLow, moduleCtrl[`DUTY_LSB_HI:`DUTY_LSB_LO]} != 10'h000;
      compareDone <= 1'b0;
    end else if (active && !compareDone && baseStep &&
                 baseNext == {dutyActive, dutyLatch}) begin
      // Clear on the edge at which the time base becomes the duty, so the
      // high time is exactly duty steps; a registered compare would add one
      // Duty longer than period never matches, so pin stays  see (RQ11) (RQ14) (RQ12)
      pwmLevel    <= 1'b0;
      compareDone <= 1'b1;
    end
  end

  // Pin routing; clearing the control register releases the pin  see (RQ20) (RQ21)
  always_comb begin
    pinOutA = 1'b0;
    pinOeA  = 1'b0;
    pinOutB = 1'b0;
    pinOeB  = 1'b0;
    if (pinReloc[`PIN_RELOC_BIT]) begin
      pinOutB = pwmMode && pwmLevel;
      pinOeB  = moduleCtrl != `RESET_BYTE && !pinDir[1];
    end else begin
      pinOutA = pwmMode && pwmLevel;
      pinOeA  = moduleCtrl != `RESET_BYTE && !pinDir[0];
    end
  end

  // Read port, data one cycle after the strobe
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdData <= `RESET_BYTE;
    end else if (rdStb) begin
      unique case (addr)
        `ADDR_PIN_RELOC:    rdData <= pinReloc;
        `ADDR_MODULE_CTRL:  rdData <= moduleCtrl;
        `ADDR_TIMER_SELECT: rdData <= timerSelect;
        `ADDR_PERIOD_LIMIT: rdData <= periodLimit[timerIdx];
        `ADDR_TIMER_CTRL:   rdData <= timerCtrl[timerIdx];
        `ADDR_TIMER_COUNT:  rdData <= timerCount[timerIdx];
        `ADDR_DUTY_LOW:     rdData <= dutyLow;
        `ADDR_DUTY_ACTIVE:  rdData <= dutyActive;
        `ADDR_PIN_DIR:      rdData <= pinDir;
        default:            rdData <= `RESET_BYTE;
      endcase
    end
  end
endmodule : standard_pwm

// *** bench/standard_pwm_checker.sv ***
`timescale 1ns/1ps
`include "pwm_regs.svh"
module standard_pwm_checker (
  input wire logic           clk,
  input wire logic           nrst,
  input wire logic           sleep,
  input wire pwm_pkg::addr_t addr,
  input wire logic [7:0]     wrData,
  input wire logic           wrStb,
  input wire logic           rdStb,
  input wire logic [7:0]     rdData,
  input wire logic           pinOutA,
  input wire logic           pinOeA,
  input wire logic           pinOutB,
  input wire logic           pinOeB
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // Count reads taken back to back while asleep
  sequence s_twoReads;
    (rdStb && sleep && addr == `ADDR_TIMER_COUNT) ##1
    (rdStb && sleep && addr == `ADDR_TIMER_COUNT);
  endsequence
  property p_rstFree; $rose(nrst) |-> !pinOeA && !pinOeB; endproperty
  property p_oneLoc; !(pinOeA && pinOeB); endproperty
  property p_relocA; wrStb && addr == `ADDR_PIN_RELOC && wrData[0] |=> !pinOeA; endproperty
  property p_dirOff; wrStb && addr == `ADDR_PIN_DIR && wrData[0] |=> !pinOeA; endproperty
  property p_ctrlOff; wrStb && addr == `ADDR_MODULE_CTRL && wrData == 8'h00 |=> !pinOeA && !pinOeB;
  endproperty
  property p_sleepHold; sleep && !wrStb |=> $stable(pinOutA) && $stable(pinOutB); endproperty
  // Shortest legal period is four clocks
  property p_minPer; $rose(pinOutA) |=> (!$rose(pinOutA)) [*3]; endproperty
  property p_cntFrz; s_twoReads |=> rdData == $past(rdData); endproperty
  a_rstFree: assert property (p_rstFree) else $error("pin driven after reset");
  a_oneLoc: assert property (p_oneLoc) else $error("both pin locations driven");
  a_relocA: assert property (p_relocA) else $error("default pin kept after move");
  a_dirOff: assert property (p_dirOff) else $error("driver on with input dir");
  a_ctrlOff: assert property (p_ctrlOff) else $error("pin kept with control clear");
  a_sleepHold: assert property (p_sleepHold) else $error("pin moved in sleep");
  a_minPer: assert property (p_minPer) else $error("period below four clocks");
  a_cntFrz: assert property (p_cntFrz) else $error("count moved in sleep");
  c_rise: cover property ($rose(pinOutA));
  c_fall: cover property ($fell(pinOutA));
  c_sleepRead: cover property (s_twoReads);
endmodule : standard_pwm_checker
bind standard_pwm standard_pwm_checker u_chk (.clk(clk), .nrst(nrst), .sleep(sleep),
  .addr(addr), .wrData(wrData), .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData),
  .pinOutA(pinOutA), .pinOeA(pinOeA), .pinOutB(pinOutB), .pinOeB(pinOeB));

// *** bench/pwm_load.sv ***
`timescale 1ns/1ps
// Load on the pin with a pull-down; measures high time and period in clocks
module pwm_load (
  input  wire logic        clk,
  input  wire logic        pinOut,
  input  wire logic        pinOe,
  output logic      [15:0] hiLen  = 16'h0,
  output logic      [15:0] perLen = 16'h0,
  output logic      [15:0] rises  = 16'h0
);
  logic        prev  = 1'b0;   // Level at the last edge
  logic [15:0] since = 16'h0;  // Clocks since the last rise
  // Released pin is pulled low, never left at its last value
  wire         level = pinOe & pinOut;
  // Edge timing, sampled once a clock
  always @(posedge clk) begin
    prev <= level;
    since <= (level && !prev) ? 16'h1 : since + 16'h1;
    if (level && !prev) begin
      perLen <= since;
      rises <= rises + 16'h1;
    end
    if (!level && prev) hiLen <= since;
  end
endmodule : pwm_load

// *** bench/testbench.sv ***
`timescale 1ns/1ps
`include "pwm_regs.svh"
module testbench;
  logic           clk = 1'b0, nrst = 1'b0, sleep = 1'b0, wrStb = 1'b0, rdStb = 1'b0;
  pwm_pkg::addr_t addr = 4'h0;
  logic [7:0]     wrData = 8'h00, rdData, v, frozenCnt;
  logic           pinOutA, pinOeA, pinOutB, pinOeB;
  logic [15:0]    hiLen, perLen, rises, n;
  int             mismatches = 0, tests_run = 0;
  int             ratio [3] = '{1, 4, 16};  // Prescale ratio per field code
  standard_pwm u_dut (.clk(clk), .nrst(nrst), .sleep(sleep), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .pinOutA(pinOutA), .pinOeA(pinOeA),
    .pinOutB(pinOutB), .pinOeB(pinOeB));
  pwm_load u_load (.clk(clk), .pinOut(pinOutA), .pinOe(pinOeA), .hiLen(hiLen),
    .perLen(perLen), .rises(rises));
  initial forever #5 clk = ~clk;
  task automatic results;
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : results
  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", name, e, g);
    end
  endtask : chk
  task automatic wr(input pwm_pkg::addr_t a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'b1;
    @(posedge clk);
    wrStb <= 1'b0;
    #1;
  endtask : wr
  task automatic rd(input pwm_pkg::addr_t a);
    @(posedge clk);
    addr <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 v = rdData;
  endtask : rd
  // Bounded wait for k further rising edges on the pin
  task automatic waitRise(input int k);
    n = rises + 16'(k);
    for (int c = 0; rises !== n; c++) begin
      if (c > 3000) begin
        mismatches++;
        results();
      end
      @(posedge clk);
    end
  endtask : waitRise
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    rd(`ADDR_PERIOD_LIMIT);
    chk("limitReset", 8'hff, v);
    rd(`ADDR_PIN_DIR);
    chk("dirReset", 8'hff, v);
    wr(4'hf, 8'h5a);
    rd(4'hf);
    chk("unmapped", 8'h00, v);
    wr(`ADDR_TIMER_SELECT, 8'h01);
    wr(`ADDR_PERIOD_LIMIT, 8'h09);
    wr(`ADDR_TIMER_SELECT, 8'h00);
    rd(`ADDR_PERIOD_LIMIT);
    chk("otherTimer", 8'hff, v);
    wr(`ADDR_TIMER_SELECT, 8'h01);
    wr(`ADDR_MODULE_CTRL, 8'h3c);
    wr(`ADDR_DUTY_LOW, 8'h06);
    wr(`ADDR_PIN_DIR, 8'h00);
    // Duty 27 against period limit 9, at each prescale ratio
    for (int i = 0; i < 3; i++) begin
      wr(`ADDR_TIMER_CTRL, 8'h04 | 8'(i));
      waitRise(3);
      chk("highTime", 16'(27 * ratio[i]), hiLen);
      chk("period", 16'(40 * ratio[i]), perLen);
    end
    wr(`ADDR_DUTY_ACTIVE, 8'h55);
    rd(`ADDR_DUTY_ACTIVE);
    chk("activeDuty", 8'h06, v);
    // New duty 11 and full postscale at once; period must not move
    wr(`ADDR_DUTY_LOW, 8'h02);
    wr(`ADDR_TIMER_CTRL, 8'h7c);
    waitRise(3);
    chk("newDuty", 16'd11, hiLen);
    chk("postscale", 16'd40, perLen);
    wr(`ADDR_MODULE_CTRL, 8'h0c);
    wr(`ADDR_DUTY_LOW, 8'h00);
    repeat (120) @(posedge clk);
    n = rises;
    repeat (100) @(posedge clk);
    chk("zeroDutyRises", n, rises);
    wr(`ADDR_DUTY_LOW, 8'h0c);
    repeat (120) @(posedge clk);
    #1 chk("longDutyPin", 16'h1, 16'(pinOutA));
    wr(`ADDR_DUTY_LOW, 8'h06);
    waitRise(2);
    sleep <= 1'b1;
    n = rises;
    // Two reads back to back while asleep, one strobe held over both
    @(posedge clk);
    addr <= `ADDR_TIMER_COUNT;
    rdStb <= 1'b1;
    @(posedge clk);
    #1 frozenCnt = rdData;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 chk("sleepCount", 16'(frozenCnt), 16'(rdData));
    // A much later read must still see the held count
    repeat (60) @(posedge clk);
    rd(`ADDR_TIMER_COUNT);
    chk("sleepCountLate", 16'(frozenCnt), 16'(v));
    @(posedge clk);
    sleep <= 1'b0;
    chk("sleepRises", n, rises);
    waitRise(1);
    wr(`ADDR_PIN_RELOC, 8'h01);
    chk("altPinOe", 16'h1, 16'(pinOeB));
    // Bounded look for the modulated level on the moved pin
    for (int c = 0; c < 100 && pinOutB !== 1'b1; c++) #10;
    chk("altPinHigh", 16'h1, 16'(pinOutB));
    wr(`ADDR_PIN_DIR, 8'h03);
    chk("altPinOff", 16'h0, 16'(pinOeB));
    wr(`ADDR_PIN_DIR, 8'h00);
    wr(`ADDR_MODULE_CTRL, 8'h00);
    chk("ctrlClearOff", 16'h0, 16'(pinOeB));
    // One more edge so the checker sees the cleared control register
    @(posedge clk);
    results();
  end
endmodule : testbench
